// >>> testbench.sv
// self-checking bench of the telemetry extrema tracker
// assumes tet_host drives the read port; samples driven on falling edge
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    miscompares++; $display("ERROR %0t got %h want %h", $time, a, e); end end
module testbench;
    import tet_pkg::*;
    logic                       clk_i, resetn_i, clear_stb_i, ch, tok;
    logic                       rd_stb, rd_page, ack, err, re;
    logic [1:0]                 clear_page_i, chan_on_i;
    logic [7:0]                 stb, rd_cmd;
    logic [15:0]                v, rdata, rv, t0, t1;
    logic signed [FIX_IN_W-1:0] fix;
    logic signed [SNS_IN_W-1:0] sns;
    int                         miscompares, check_count;
    logic [7:0]  cm [6] = '{8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hde, 8'hdd};
    logic [15:0] ev [6] = '{16'h7c00, 16'h7bff, 16'h7c00, 16'h7bff,
                            16'h7c00, 16'hf800};
    tet_tracker i_dut (.clk_i, .resetn_i, .clear_stb_i, .clear_page_i,
        .chan_on_i, .vin_stb_i(stb[0]), .vin_i(v), .iin_stb_i(stb[1]),
        .iin_i(v), .pin_stb_i(stb[2]), .pin_i(v), .vout_stb_i(stb[3]),
        .vout_ch_i(ch), .vout_i(v), .iout_stb_i(stb[4]), .iout_ch_i(ch),
        .iout_i(v), .iout_fix_i(fix), .iout_sns_i(sns), .pout_stb_i(stb[5]),
        .pout_ch_i(ch), .pout_i(v), .temp_stb_i(stb[6]), .temp_ch_i(ch),
        .temp_ext_i(v), .temp_ok_i(tok), .tint_stb_i(stb[7]), .tint_i(v),
        .rd_stb_i(rd_stb), .rd_cmd_i(rd_cmd), .rd_page_i(rd_page),
        .rd_data_o(rdata), .rd_ack_o(ack), .rd_err_o(err),
        .temp1_ch0_o(t0), .temp1_ch1_o(t1));
    tet_host i_host (.clk_i, .rd_data_i(rdata), .rd_ack_i(ack),
        .rd_err_i(err), .rd_stb_o(rd_stb), .rd_cmd_o(rd_cmd),
        .rd_page_o(rd_page));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic rc(input logic [7:0] c, input logic p,
                      input logic [15:0] x);
        i_host.rd(c, p, rv, re);
        `CHK({re, rv}, {1'b0, x})
    endtask
    task automatic fire(input logic [7:0] s, input logic [15:0] x);
        @(negedge clk_i);
        stb = s;
        v   = x;
        @(negedge clk_i);
        stb = 8'h00;
    endtask
    task automatic clr(input logic [1:0] pg);
        @(negedge clk_i);
        clear_stb_i  = 1'b1;
        clear_page_i = pg;
        @(negedge clk_i);
        clear_stb_i  = 1'b0;
    endtask
    initial begin
        #100us;
        miscompares++;
        test_done();
    end
    initial begin
        {resetn_i, clear_stb_i, clear_page_i, chan_on_i, stb, v} = '0;
        {ch, fix, sns} = '0;
        tok = 1'b1;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rc(cm[i], 1'b0, ev[i]);
        end
        // raw 0xf820 is larger but decodes to 16, below 20
        fire(8'h07, 16'hf820);
        fire(8'h07, 16'h0014);
        rc(8'hc4, 1'b0, 16'h0014);
        rc(8'hc5, 1'b0, 16'hf820);
        rc(8'hc6, 1'b1, 16'h0014);
        rc(8'hc7, 1'b1, 16'hf820);
        rc(8'hde, 1'b0, 16'h0014);
        fire(8'h08, 16'h1234);
        clr(2'b10);
        rc(8'hc4, 1'b0, 16'h7c00);
        rc(8'hc7, 1'b0, 16'h7bff);
        rc(8'hdd, 1'b0, 16'h1234);
        rc(8'h8b, 1'b0, 16'h1234);
        clr(2'b01);
        rc(8'hdd, 1'b0, 16'hf800);
        fire(8'h07, 16'h0014);
        chan_on_i = 2'b10;
        rc(8'hc5, 1'b0, 16'h7bff);
        rc(8'hde, 1'b0, 16'h7c00);
        rc(8'h88, 1'b0, 16'h0014);
        rc(8'h89, 1'b0, 16'h0014);
        rc(8'h97, 1'b1, 16'h0014);
        fix = 24'sd40000;
        sns = -18'sd506;
        fire(8'h10, 16'h0000);
        rc(8'hbb, 1'b0, 16'h7fff);
        rc(8'hfa, 1'b0, 16'h01fa);
        fix = -24'sd2;
        fire(8'h10, 16'h0000);
        rc(8'hbb, 1'b0, 16'hfffe);
        fix = -24'sd40000;
        fire(8'h10, 16'h0abc);
        rc(8'hbb, 1'b0, 16'h8000);
        rc(8'h8c, 1'b0, 16'h0abc);
        fire(8'h80, 16'h2222);
        fire(8'h40, 16'h1111);
        ch  = 1'b1;
        tok = 1'b0;
        fire(8'h40, 16'h0bad);
        rc(8'h8d, 1'b1, 16'h2222);
        rc(8'h8d, 1'b0, 16'h1111);
        rc(8'h8e, 1'b0, 16'h2222);
        `CHK(t1, 16'h2222)
        `CHK(t0, 16'h1111)
        fire(8'h20, 16'h3333);
        rc(8'h96, 1'b1, 16'h3333);
        rc(8'h96, 1'b0, 16'h0000);
        i_host.rd(8'h00, 1'b0, rv, re);
        `CHK({re, rv}, 17'h10000)
        test_done();
    end
endmodule

// >>> tet_cur_fmt.sv
// fixed-step current word and raw sense magnitude, combinational
// assumes current arrives already in 2.5 ma counts, sense as signed raw
`timescale 1ns/10ps
module tet_cur_fmt (
    input  wire logic signed [tet_pkg::FIX_IN_W-1:0] fix_i,
    input  wire logic signed [tet_pkg::SNS_IN_W-1:0] sns_i,
    output logic             [15:0]                  fix_o,
    output logic             [15:0]                  sns_o
);
    import tet_pkg::*;

    localparam logic signed [FIX_IN_W-1:0] POS_LIM = FIX_IN_W'(32767);
    localparam logic signed [FIX_IN_W-1:0] NEG_LIM = -FIX_IN_W'(32768);

    logic [SNS_IN_W-1:0] sns_abs;

    // clamp: beyond the limit only the standard reading is meaningful
    always_comb begin
        if (fix_i > POS_LIM) begin
            fix_o = FIX_POS_SAT;
        end else if (fix_i < NEG_LIM) begin
            fix_o = FIX_NEG_SAT;
        end else begin
            fix_o = fix_i[15:0];
        end
    end

    // magnitude only; scale (0.025 or 0.75) is applied by the reader
    always_comb begin
        sns_abs = sns_i[SNS_IN_W-1] ? SNS_IN_W'(-sns_i) : sns_i;
        if (|sns_abs[SNS_IN_W-1:16]) begin
            sns_o = SNS_SAT;
        end else begin
            sns_o = sns_abs[15:0];
        end
    end
endmodule

// >>> tet_extreme.sv
// one running peak or minimum tracker of a 16-bit telemetry word
// assumes sample strobe and init are one-cycle pulses on clk_i
`timescale 1ns/10ps
module tet_extreme #(
    parameter bit          IS_MAX = 1'b1,
    parameter bit          IS_L11 = 1'b1,
    parameter logic [15:0] RST    = 16'h0000
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        init_i,
    input  wire logic        smp_stb_i,
    input  wire logic [15:0] smp_i,
    output logic      [15:0] value_o
);
    import tet_pkg::*;

    logic                    fresh_reg;
    logic signed [DEC_W-1:0] dec_new;
    logic signed [DEC_W-1:0] dec_old;
    logic                    better;

    // decode to a common fixed point so patterns compare by value
    function automatic logic signed [DEC_W-1:0] dec(input logic [15:0] w);
        logic signed [DEC_W-1:0] m;
        logic [4:0]              sh;
        m  = DEC_W'(signed'(w[L11_EXP_LSB-1:0]));
        sh = {~w[15], w[14:L11_EXP_LSB]};
        if (IS_L11) begin
            dec = m <<< sh;
        end else begin
            dec = signed'(DEC_W'(w));
        end
    endfunction

    assign dec_new = dec(smp_i);
    assign dec_old = dec(value_o);
    assign better  = IS_MAX ? (dec_new > dec_old) : (dec_new < dec_old);

    // ******************************************************
    // tracker update
    // ******************************************************
    // sample beside init is kept: init then sample, so nothing lost
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            value_o   <= RST;
            fresh_reg <= 1'b1;
        end else if (smp_stb_i && (init_i || fresh_reg || better)) begin
            value_o   <= smp_i;
            fresh_reg <= 1'b0;
        end else if (init_i) begin
            value_o   <= RST;
            fresh_reg <= 1'b1;
        end
    end

    a_track_hold : assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        !smp_stb_i && !init_i |=> $stable(value_o))
        else $error("tracker changed without sample or init");
    a_track_keep : assert property (@(posedge clk_i)
        disable iff (!resetn_i) smp_stb_i && !init_i && !fresh_reg |=>
        (IS_MAX ? dec(value_o) >= $past(dec_old)
                : dec(value_o) <= $past(dec_old)))
        else $error("tracker moved the wrong way");
    a_track_init : assert property (@(posedge clk_i)
        disable iff (!resetn_i) init_i && !smp_stb_i |=> value_o == RST)
        else $error("tracker not set to reset value");
endmodule

// >>> tet_host.sv
// host model: issues telemetry reads on the command read port
// assumes the tracker samples its read request on rising clk_i
`timescale 1ns/10ps
module tet_host (
    input  wire logic        clk_i,
    input  wire logic [15:0] rd_data_i,
    input  wire logic        rd_ack_i,
    input  wire logic        rd_err_i,
    output logic             rd_stb_o,
    output logic      [7:0]  rd_cmd_o,
    output logic             rd_page_o
);
    initial begin
        rd_stb_o  = 1'b0;
        rd_cmd_o  = 8'h00;
        rd_page_o = 1'b0;
    end
    // ack stands one cycle only, so it is caught in that cycle
    task automatic rd(input logic [7:0] c, input logic p,
                      output logic [15:0] d, output logic e);
        @(negedge clk_i);
        rd_stb_o  = 1'b1;
        rd_cmd_o  = c;
        rd_page_o = p;
        @(negedge clk_i);
        d = rd_ack_i ? rd_data_i : 16'hxxxx;
        e = rd_err_i;
        rd_stb_o  = 1'b0;
        rd_cmd_o  = ~c;
        rd_page_o = ~p;
    endtask
endmodule

// >>> tet_pkg.sv
// telemetry extrema tracker: command codes, reset values, limits
// assumes 16-bit telemetry words (L11, L16 or fixed-step formats)
package tet_pkg;
    localparam int unsigned   TET_W        = 16;
    localparam int unsigned   TET_CH       = 2;
    // ******************************************************
    // command codes
    // ******************************************************
    localparam logic [7:0]    CMD_VIN      = 8'h88;
    localparam logic [7:0]    CMD_IIN      = 8'h89;
    localparam logic [7:0]    CMD_VOUT     = 8'h8b;
    localparam logic [7:0]    CMD_IOUT     = 8'h8c;
    localparam logic [7:0]    CMD_TEMP1    = 8'h8d;
    localparam logic [7:0]    CMD_TEMP2    = 8'h8e;
    localparam logic [7:0]    CMD_POUT     = 8'h96;
    localparam logic [7:0]    CMD_PIN      = 8'h97;
    localparam logic [7:0]    CMD_IOUT_FIX = 8'hbb;
    localparam logic [7:0]    CMD_IIN_MAX  = 8'hc4;
    localparam logic [7:0]    CMD_IIN_MIN  = 8'hc5;
    localparam logic [7:0]    CMD_PIN_MAX  = 8'hc6;
    localparam logic [7:0]    CMD_PIN_MIN  = 8'hc7;
    localparam logic [7:0]    CMD_VOUT_MAX = 8'hdd;
    localparam logic [7:0]    CMD_VIN_MAX  = 8'hde;
    localparam logic [7:0]    CMD_SNS_V    = 8'hfa;
    // ******************************************************
    // tracker reset values
    // ******************************************************
    localparam logic [15:0]   RST_PEAK     = 16'h7c00;
    localparam logic [15:0]   RST_MIN      = 16'h7bff;
    localparam logic [15:0]   RST_VOUT_PK  = 16'hf800;
    // ******************************************************
    // fixed-step current: 2.5 ma per count, +-81.92 a limit
    // ******************************************************
    localparam int unsigned   FIX_IN_W     = 24;
    localparam int unsigned   SNS_IN_W     = 18;
    localparam logic [15:0]   FIX_POS_SAT  = 16'h7fff;
    localparam logic [15:0]   FIX_NEG_SAT  = 16'h8000;
    localparam logic [15:0]   SNS_SAT      = 16'hffff;
    // ******************************************************
    // l11 field layout
    // ******************************************************
    localparam int unsigned   L11_EXP_LSB  = 11;
    localparam int unsigned   DEC_W        = 48;
endpackage

// >>> tet_tracker.sv
// telemetry extrema tracker: latest readings, peak/min trackers,
// temperature fallback and command-code read port
// assumes samples come from the adc sequencer as one-cycle strobes,
// and the serial command decoder presents reads as rd_stb_i pulses
//
// Contract
// - input current peak tracked; 0x7C00 on reset, any clear, turn-on
// - input current minimum tracked; 0x7BFF on same three events
// - input power peak tracked; 0x7C00 on same three events
// - input power minimum tracked; 0x7BFF on same three events
// - input voltage peak tracked; 0x7C00 on same three events
// - per-page output voltage peak; 0xF800 on reset, page clear, turn-on
// - paged external diode temperature feeds all temperature processing
// - invalid external reading replaced by internal junction temperature
// - internal temperature unpaged, affects nothing unless substituted
// - fixed-step output current: signed 16 bits, 2.5 mA per count
// - fixed-step current saturates at plus or minus 81.92 A
// - sense voltage: unsigned magnitude of last conversion, uncorrected
// - output power read returns most recent per-channel conversion
`timescale 1ns/10ps
module tet_tracker (
    input  wire logic                                 clk_i,
    input  wire logic                                 resetn_i,
    input  wire logic                                 clear_stb_i,
    input  wire logic [tet_pkg::TET_CH-1:0]           clear_page_i,
    input  wire logic [tet_pkg::TET_CH-1:0]           chan_on_i,
    input  wire logic                                 vin_stb_i,
    input  wire logic [15:0]                          vin_i,
    input  wire logic                                 iin_stb_i,
    input  wire logic [15:0]                          iin_i,
    input  wire logic                                 pin_stb_i,
    input  wire logic [15:0]                          pin_i,
    input  wire logic                                 vout_stb_i,
    input  wire logic                                 vout_ch_i,
    input  wire logic [15:0]                          vout_i,
    input  wire logic                                 iout_stb_i,
    input  wire logic                                 iout_ch_i,
    input  wire logic [15:0]                          iout_i,
    input  wire logic signed [tet_pkg::FIX_IN_W-1:0]  iout_fix_i,
    input  wire logic signed [tet_pkg::SNS_IN_W-1:0]  iout_sns_i,
    input  wire logic                                 pout_stb_i,
    input  wire logic                                 pout_ch_i,
    input  wire logic [15:0]                          pout_i,
    input  wire logic                                 temp_stb_i,
    input  wire logic                                 temp_ch_i,
    input  wire logic [15:0]                          temp_ext_i,
    input  wire logic                                 temp_ok_i,
    input  wire logic                                 tint_stb_i,
    input  wire logic [15:0]                          tint_i,
    input  wire logic                                 rd_stb_i,
    input  wire logic [7:0]                           rd_cmd_i,
    input  wire logic                                 rd_page_i,
    output logic      [15:0]                          rd_data_o,
    output logic                                      rd_ack_o,
    output logic                                      rd_err_o,
    output logic      [15:0]                          temp1_ch0_o,
    output logic      [15:0]                          temp1_ch1_o
);
    import tet_pkg::*;

    // ******************************************************
    // declarations
    // ******************************************************
    logic [TET_CH-1:0] on_prev_reg;
    logic [TET_CH-1:0] turn_on;
    logic              in_init;
    logic [TET_CH-1:0] vout_init;
    logic [15:0]       vin_reg;
    logic [15:0]       iin_reg;
    logic [15:0]       pin_reg;
    logic [15:0]       tint_reg;
    logic [15:0]       vout_reg [TET_CH];
    logic [15:0]       iout_reg [TET_CH];
    logic [15:0]       fix_reg  [TET_CH];
    logic [15:0]       sns_reg  [TET_CH];
    logic [15:0]       pout_reg [TET_CH];
    logic [15:0]       temp1_reg[TET_CH];
    logic [TET_CH-1:0] ext_ok_reg;
    logic [15:0]       iin_max;
    logic [15:0]       iin_min;
    logic [15:0]       pin_max;
    logic [15:0]       pin_min;
    logic [15:0]       vin_max;
    logic [15:0]       vout_max [TET_CH];
    logic [15:0]       fix_word;
    logic [15:0]       sns_word;
    logic [15:0]       rd_data_next;
    logic              rd_err_next;

    // ******************************************************
    // tracker restart events
    // ******************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            on_prev_reg <= '0;
        end else begin
            on_prev_reg <= chan_on_i;
        end
    end

    // a clear on any page restarts input-side trackers
    assign turn_on   = chan_on_i & ~on_prev_reg;
    assign in_init   = clear_stb_i | (|turn_on);
    assign vout_init = ({TET_CH{clear_stb_i}} & clear_page_i) | turn_on;

    // ******************************************************
    // input-side trackers
    // ******************************************************
    tet_extreme #(.IS_MAX(1'b1), .IS_L11(1'b1), .RST(RST_PEAK))
    u_iin_max (
        .clk_i(clk_i), .resetn_i(resetn_i), .init_i(in_init),
        .smp_stb_i(iin_stb_i), .smp_i(iin_i), .value_o(iin_max));
    tet_extreme #(.IS_MAX(1'b0), .IS_L11(1'b1), .RST(RST_MIN))
    u_iin_min (
        .clk_i(clk_i), .resetn_i(resetn_i), .init_i(in_init),
        .smp_stb_i(iin_stb_i), .smp_i(iin_i), .value_o(iin_min));
    tet_extreme #(.IS_MAX(1'b1), .IS_L11(1'b1), .RST(RST_PEAK))
    u_pin_max (
        .clk_i(clk_i), .resetn_i(resetn_i), .init_i(in_init),
        .smp_stb_i(pin_stb_i), .smp_i(pin_i), .value_o(pin_max));
    tet_extreme #(.IS_MAX(1'b0), .IS_L11(1'b1), .RST(RST_MIN))
    u_pin_min (
        .clk_i(clk_i), .resetn_i(resetn_i), .init_i(in_init),
        .smp_stb_i(pin_stb_i), .smp_i(pin_i), .value_o(pin_min));
    tet_extreme #(.IS_MAX(1'b1), .IS_L11(1'b1), .RST(RST_PEAK))
    u_vin_max (
        .clk_i(clk_i), .resetn_i(resetn_i), .init_i(in_init),
        .smp_stb_i(vin_stb_i), .smp_i(vin_i), .value_o(vin_max));

    // ******************************************************
    // per-channel output voltage peaks
    // ******************************************************
    for (genvar c = 0; c < TET_CH; c++) begin : g_vout
        // 0xf800 marks an empty tracker; first sample always taken
        tet_extreme #(.IS_MAX(1'b1), .IS_L11(1'b0), .RST(RST_VOUT_PK))
        u_vout_max (
            .clk_i(clk_i), .resetn_i(resetn_i), .init_i(vout_init[c]),
            .smp_stb_i(vout_stb_i && (vout_ch_i == 1'(c))),
            .smp_i(vout_i), .value_o(vout_max[c]));
    end

    tet_cur_fmt u_fmt (
        .fix_i (iout_fix_i),
        .sns_i (iout_sns_i),
        .fix_o (fix_word),
        .sns_o (sns_word)
    );

    // ******************************************************
    // latest readings
    // ******************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vin_reg <= '0;
            iin_reg <= '0;
            pin_reg <= '0;
        end else begin
            if (vin_stb_i) begin
                vin_reg <= vin_i;
            end
            if (iin_stb_i) begin
                iin_reg <= iin_i;
            end
            if (pin_stb_i) begin
                pin_reg <= pin_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vout_reg <= '{default: '0};
            iout_reg <= '{default: '0};
            fix_reg  <= '{default: '0};
            sns_reg  <= '{default: '0};
            pout_reg <= '{default: '0};
        end else begin
            if (vout_stb_i) begin
                vout_reg[vout_ch_i] <= vout_i;
            end
            if (iout_stb_i) begin
                iout_reg[iout_ch_i] <= iout_i;
                fix_reg[iout_ch_i]  <= fix_word;
                sns_reg[iout_ch_i]  <= sns_word;
            end
            if (pout_stb_i) begin
                pout_reg[pout_ch_i] <= pout_i;
            end
        end
    end

    // ******************************************************
    // temperature selection
    // ******************************************************
    // internal reading only reaches a channel that lost its diode or has had no diode reading since reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tint_reg   <= '0;
            ext_ok_reg <= '0;
            temp1_reg  <= '{default: '0};
        end else begin
            if (tint_stb_i) begin
                tint_reg <= tint_i;
            end
            for (int c = 0; c < TET_CH; c++) begin
                if (temp_stb_i && temp_ch_i == 1'(c)) begin
                    ext_ok_reg[c] <= temp_ok_i;
                    if (temp_ok_i) begin
                        temp1_reg[c] <= temp_ext_i;
                    end else begin
                        temp1_reg[c] <= tint_stb_i ? tint_i
                                                   : tint_reg;
                    end
                end else if (tint_stb_i && !ext_ok_reg[c]) begin
                    temp1_reg[c] <= tint_i;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp1_ch0_o <= '0;
            temp1_ch1_o <= '0;
        end else begin
            temp1_ch0_o <= temp1_reg[0];
            temp1_ch1_o <= temp1_reg[1];
        end
    end

    // ******************************************************
    // read port
    // ******************************************************
    always_comb begin
        rd_err_next  = 1'b0;
        rd_data_next = '0;
        unique case (rd_cmd_i)
            CMD_VIN:      rd_data_next = vin_reg;
            CMD_IIN:      rd_data_next = iin_reg;
            CMD_PIN:      rd_data_next = pin_reg;
            CMD_VOUT:     rd_data_next = vout_reg[rd_page_i];
            CMD_IOUT:     rd_data_next = iout_reg[rd_page_i];
            CMD_TEMP1:    rd_data_next = temp1_reg[rd_page_i];
            CMD_TEMP2:    rd_data_next = tint_reg;
            CMD_POUT:     rd_data_next = pout_reg[rd_page_i];
            CMD_IOUT_FIX: rd_data_next = fix_reg[rd_page_i];
            CMD_IIN_MAX:  rd_data_next = iin_max;
            CMD_IIN_MIN:  rd_data_next = iin_min;
            CMD_PIN_MAX:  rd_data_next = pin_max;
            CMD_PIN_MIN:  rd_data_next = pin_min;
            CMD_VOUT_MAX: rd_data_next = vout_max[rd_page_i];
            CMD_VIN_MAX:  rd_data_next = vin_max;
            CMD_SNS_V:    rd_data_next = sns_reg[rd_page_i];
            default:      rd_err_next  = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o <= '0;
            rd_ack_o  <= 1'b0;
            rd_err_o  <= 1'b0;
        end else begin
            rd_ack_o <= rd_stb_i;
            rd_err_o <= rd_stb_i && rd_err_next;
            if (rd_stb_i) begin
                rd_data_o <= rd_data_next;
            end
        end
    end

    // ******************************************************
    // assertions
    // ******************************************************
    a_iin_max_clr : assert property (@(posedge clk_i)
        disable iff (!resetn_i) clear_stb_i && !iin_stb_i
        |=> iin_max == 16'h7c00)
        else $error("input current peak not restarted by clear");
    a_iin_min_on : assert property (@(posedge clk_i)
        disable iff (!resetn_i) (|turn_on) && !iin_stb_i
        |=> iin_min == 16'h7bff)
        else $error("input current minimum not restarted by turn-on");
    a_pin_max_on : assert property (@(posedge clk_i)
        disable iff (!resetn_i) (|turn_on) && !pin_stb_i
        |=> pin_max == 16'h7c00)
        else $error("input power peak not restarted by turn-on");
    a_pin_min_clr : assert property (@(posedge clk_i)
        disable iff (!resetn_i) clear_stb_i && !pin_stb_i
        |=> pin_min == 16'h7bff)
        else $error("input power minimum not restarted by clear");
    a_vin_max_clr : assert property (@(posedge clk_i)
        disable iff (!resetn_i) clear_stb_i && !vin_stb_i
        |=> vin_max == 16'h7c00)
        else $error("input voltage peak not restarted by clear");
    a_vout_page_only : assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        clear_stb_i && clear_page_i == 2'b01 && !turn_on[1] && !vout_stb_i
        |=> $stable(vout_max[1]))
        else $error("output peak of other page disturbed by clear");
    a_temp_fallback : assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        temp_stb_i && !temp_ok_i && !tint_stb_i
        |=> temp1_reg[$past(temp_ch_i)] == $past(tint_reg))
        else $error("internal temperature not substituted");
    a_temp_ext_used : assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        temp_stb_i && temp_ok_i && !temp_ch_i
        |=> ##1 temp1_ch0_o == $past(temp_ext_i, 2))
        else $error("external temperature not forwarded");
    a_fix_sat : assert property (@(posedge clk_i)
        disable iff (!resetn_i) iout_stb_i && iout_fix_i > 24'sd32767
        |=> fix_reg[$past(iout_ch_i)] == 16'h7fff)
        else $error("fixed-step current not clamped");
    a_sns_abs : assert property (@(posedge clk_i)
        disable iff (!resetn_i) iout_stb_i && iout_sns_i == -18'sd506
        |=> sns_reg[$past(iout_ch_i)] == 16'h01fa)
        else $error("sense magnitude wrong");
    a_pout_read : assert property (@(posedge clk_i)
        disable iff (!resetn_i) rd_stb_i && rd_cmd_i == 8'h96
        |=> rd_ack_o && rd_data_o == $past(pout_reg[rd_page_i]))
        else $error("output power read not returned next cycle");

    c_clear_all : cover property (@(posedge clk_i) disable iff (!resetn_i)
        clear_stb_i && clear_page_i == 2'b11);
    c_fallback : cover property (@(posedge clk_i) disable iff (!resetn_i)
        temp_stb_i && !temp_ok_i ##1 rd_stb_i && rd_cmd_i == 8'h8d);
    c_turn_on : cover property (@(posedge clk_i) disable iff (!resetn_i)
        turn_on[1] ##[1:4] vout_stb_i);
endmodule
